// *** hdl/raic_params.svh ***
/*
 constants for the reset and idle control block: counts, field positions, reset values.
 assumes a 100 MHz sys_clk standing for the oscillator clock.
*/
// Function
// R1 - internal reset comes from power monitor, both watchdogs and reset pin
// R2 - reset pin held asserted keeps internal reset active; the code lets it drop for two cycles after its own watchdog pulse ends
// R3 - hardware watchdog expiry drives a 96-clock reset pulse onto the pin
// R4 - power monitor asserts reset at once when power is first applied
// R5 - after supply is safe, reset holds until crystal input toggles
// R6 - count 1024 clocks after valid clock, then release power-up reset
// R7 - supply drop during operation asserts reset at once, no delay count
// R8 - power monitor reset goes to core, memories and peripherals
// R9 - setting power control bit 0 enters idle mode
// R10 - idle stops cpu clock, keeps interrupt, timer, serial clocks running
// R11 - idle keeps cpu registers and port pins frozen
// R12 - idle drives address latch strobe and program store strobe high
// R13 - any enabled interrupt clears idle bit and ends idle
// R14 - hardware reset ends idle; pin needs holding only 24 clocks
// R15 - idle request bit cleared by hardware on interrupt or reset
// R16 - power-off flag set on power-up, software may set or clear it
// R17 - internal reset is OR of sources, released synchronously
`ifndef RAIC_PARAMS_SVH
`define RAIC_PARAMS_SVH
`define RAIC_WDT_PULSE_CLKS 96
`define RAIC_PU_DELAY_CLKS 1024
`define RAIC_PIN_MIN_CLKS 24
`define RAIC_IDLE_BIT 0
`define RAIC_POF_BIT 4
`define RAIC_POWER_CONTROL_REG_RESET 8'h10
`define RAIC_POWER_CONTROL_REG_WMASK 8'hdf
`endif

// *** hdl/raic_pkg.sv ***
/*
 types of the reset and idle control block.
 assumes raic_params.svh is included by the design files.
*/
package raic_pkg;
   typedef enum logic [2:0] {
      RAIC_PU_OFF = 3'b001,
      RAIC_PU_WAIT_CLK = 3'b010,
      RAIC_PU_RUN = 3'b100
   } raic_pu_state_t;
   typedef struct packed {
      logic we;
      logic [7:0] wdata;
   } raic_power_control_reg_wr_t;
   typedef struct packed {
      logic cpu_clk_en;
      logic periph_clk_en;
      logic hold_state;
   } raic_clk_ctl_t;
endpackage

// *** hdl/raic_pulse_counter.sv ***
/*
 raic_pulse_counter: down counter that stretches a start pulse to a fixed length.
 assumes start is synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module raic_pulse_counter #(
   parameter int unsigned LEN = 96
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic start,
   output logic busy
);
   localparam int W = $clog2(LEN + 1);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   assign cnt_d = start ? W'(LEN) : (cnt_q != '0) ? cnt_q - W'(1) : cnt_q;
   assign busy = (cnt_q != '0);
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule
`default_nettype wire

// *** hdl/raic_reset_idle.sv ***
/*
 raic_reset_idle: reset combiner, power-up sequencer, watchdog reset-out and idle control.
 assumes the supply-safe level, crystal activity and reset pin come from outside the
 clock domain; power control writes and interrupt requests come from the core on sys_clk.
*/
`timescale 1ns/1ps
`include "raic_params.svh"
`default_nettype none
module raic_reset_idle (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic supply_safe,
   input wire logic crystal_input,
   input wire logic rst_pin_in,
   output logic rst_pin_out,
   output logic rst_pin_oe,
   input wire logic hw_watchdog_expire,
   input wire logic counter_array_wdt_expire,
   input wire raic_pkg::raic_power_control_reg_wr_t power_control_reg_wr,
   input wire logic enabled_irq,
   output logic [7:0] power_control_reg,
   output logic internal_reset,
   output raic_pkg::raic_clk_ctl_t clk_ctl,
   output logic ale_force_high,
   output logic program_store_strobe_force_high,
   output logic idle_active
);
   // two-stage synchronisers for outside levels
   logic safe_s1_q, safe_q;
   logic xtal_s1_q, xtal_q, xtal_prev_q;
   logic pin_s1_q, pin_q;
   // supply starts unsafe so reset holds until the level is really seen
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         safe_s1_q <= 1'b0;
         safe_q <= 1'b0;
      end else begin
         safe_s1_q <= supply_safe;
         safe_q <= safe_s1_q;
      end
   end
   // third stage only feeds the edge detector, never the first stage
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         xtal_s1_q <= 1'b0;
         xtal_q <= 1'b0;
         xtal_prev_q <= 1'b0;
      end else begin
         xtal_s1_q <= crystal_input;
         xtal_q <= xtal_s1_q;
         xtal_prev_q <= xtal_q;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         pin_s1_q <= 1'b0;
         pin_q <= 1'b0;
      end else begin
         pin_s1_q <= rst_pin_in;
         pin_q <= pin_s1_q;
      end
   end

   // a level counts once seen; supply loss forgets it so power-up starts over
   function automatic logic seen_next(input logic seen, input logic safe, input logic hit);
      return safe & (seen | hit);
   endfunction

   // crystal seen at both levels; high and low each observed
   logic seen_hi_q, seen_lo_q;
   wire clk_valid = seen_hi_q & seen_lo_q; // R5
   wire xtal_edge = xtal_q ^ xtal_prev_q;
   wire seen_hi_d = seen_next(seen_hi_q, safe_q, xtal_edge & xtal_q);
   wire seen_lo_d = seen_next(seen_lo_q, safe_q, xtal_edge & !xtal_q);
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         seen_hi_q <= 1'b0;
         seen_lo_q <= 1'b0;
      end else begin
         seen_hi_q <= seen_hi_d;
         seen_lo_q <= seen_lo_d;
      end
   end

   // power-up sequencer
   raic_pkg::raic_pu_state_t pu_q, pu_d;
   logic [10:0] pu_cnt_q, pu_cnt_d;
   wire pu_done = (pu_cnt_q == 11'(`RAIC_PU_DELAY_CLKS - 1));
   always_comb begin
      pu_d = pu_q;
      pu_cnt_d = pu_cnt_q;
      case (pu_q)
         raic_pkg::RAIC_PU_OFF: begin
            pu_cnt_d = 11'h000;
            if (safe_q) begin
               pu_d = raic_pkg::RAIC_PU_WAIT_CLK;
            end
         end
         raic_pkg::RAIC_PU_WAIT_CLK: begin
            if (clk_valid) begin
               pu_cnt_d = pu_cnt_q + 11'h001; // R6
               if (pu_done) begin
                  pu_d = raic_pkg::RAIC_PU_RUN;
               end
            end
         end
         raic_pkg::RAIC_PU_RUN: begin
            pu_cnt_d = 11'h000;
         end
         default: begin
            pu_d = raic_pkg::RAIC_PU_OFF;
            pu_cnt_d = 11'h000;
         end
      endcase
      // supply loss overrides every state, no delay count
      if (!safe_q) begin
         pu_d = raic_pkg::RAIC_PU_OFF; // R7
         pu_cnt_d = 11'h000;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         pu_q <= raic_pkg::RAIC_PU_OFF; // R4
         pu_cnt_q <= 11'h000;
      end else begin
         pu_q <= pu_d;
         pu_cnt_q <= pu_cnt_d;
      end
   end
   wire por_reset = (pu_q != raic_pkg::RAIC_PU_RUN); // R4 R8

   // watchdog reset-out pulse on the pin
   logic wdt_busy;
   raic_pulse_counter #(
      .LEN(`RAIC_WDT_PULSE_CLKS)
   ) u_wdt_pulse (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .start(hw_watchdog_expire & !por_reset),
      .busy(wdt_busy)
   );
   assign rst_pin_out = 1'b1; // R3
   assign rst_pin_oe = wdt_busy; // R3

   // own drive is excluded from the pin term to avoid latching the reset forever
   // the pin echo of our pulse arrives two syncs late, so mask that long too;
   // an outside reset shorter than those two cycles after a pulse is lost
   logic [1:0] own_drive_q;
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         own_drive_q <= 2'b00;
      end else begin
         own_drive_q <= {own_drive_q[0], wdt_busy};
      end
   end
   wire own_drive = wdt_busy | own_drive_q[0] | own_drive_q[1];
   wire pin_reset = pin_q & !own_drive; // R2
   wire any_src = por_reset | wdt_busy | counter_array_wdt_expire | pin_reset; // R1 R17

   // release is registered so downstream sees a clean sys_clk edge
   logic int_rst_q;
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         int_rst_q <= 1'b1;
      end else begin
         int_rst_q <= any_src; // R17
      end
   end
   assign internal_reset = int_rst_q | por_reset; // R8 R7

   // reserved bit never stores a one
   function automatic logic [7:0] power_control_reg_masked(input logic [7:0] wdata);
      return wdata & `RAIC_POWER_CONTROL_REG_WMASK;
   endfunction

   // only the power-off flag survives a reset
   function automatic logic [7:0] power_control_reg_after_reset(input logic [7:0] cur, input logic pof_set);
      logic [7:0] v;
      v = 8'h00;
      v[`RAIC_POF_BIT] = cur[`RAIC_POF_BIT] | pof_set;
      return v;
   endfunction

   // power control register
   logic [7:0] power_control_reg_q, power_control_reg_d;
   logic pof_set_q;
   wire power_control_reg_written = power_control_reg_wr.we & !internal_reset;
   always_comb begin
      power_control_reg_d = power_control_reg_q;
      if (power_control_reg_written) begin
         power_control_reg_d = power_control_reg_masked(power_control_reg_wr.wdata);
      end
      if (enabled_irq) begin
         power_control_reg_d[`RAIC_IDLE_BIT] = 1'b0; // R13 R15
      end
      // hardware set wins over a software clear in the same cycle
      if (pof_set_q) begin
         power_control_reg_d[`RAIC_POF_BIT] = 1'b1; // R16
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         power_control_reg_q <= `RAIC_POWER_CONTROL_REG_RESET;
         pof_set_q <= 1'b0;
      end else if (internal_reset) begin
         // reset ends idle; pof kept so software can tell the reset type
         power_control_reg_q <= power_control_reg_after_reset(power_control_reg_q, pof_set_q); // R14 R15
         pof_set_q <= por_reset; // R16
      end else begin
         power_control_reg_q <= power_control_reg_d; // R9
         pof_set_q <= 1'b0;
      end
   end
   assign power_control_reg = power_control_reg_q;

   // idle: cpu clock gated, peripherals run, core and ports frozen
   wire idle = power_control_reg_q[`RAIC_IDLE_BIT]; // R9
   assign idle_active = idle;
   assign clk_ctl.cpu_clk_en = !idle; // R10
   assign clk_ctl.periph_clk_en = 1'b1; // R10
   assign clk_ctl.hold_state = idle; // R11
   assign ale_force_high = idle; // R12
   assign program_store_strobe_force_high = idle; // R12
endmodule
`default_nettype wire

// *** verif/raic_props.sv ***
/* checker on the ports of raic_reset_idle.
   assumes a bind from the bench top. */
`timescale 1ns/1ps
`default_nettype none
module raic_props (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic supply_safe,
   input wire logic rst_pin_out,
   input wire logic rst_pin_oe,
   input wire logic hw_watchdog_expire,
   input wire logic counter_array_wdt_expire,
   input wire raic_pkg::raic_power_control_reg_wr_t power_control_reg_wr,
   input wire logic enabled_irq,
   input wire logic [7:0] power_control_reg,
   input wire logic internal_reset,
   input wire raic_pkg::raic_clk_ctl_t clk_ctl,
   input wire logic ale_force_high,
   input wire logic program_store_strobe_force_high,
   input wire logic idle_active
);
   logic [7:0] oe_cnt_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // restarts with each expiry, as a new expiry restarts the pulse when no power-up reset is active
   always_ff @(posedge sys_clk) begin
      if (!reset_n || hw_watchdog_expire || !rst_pin_oe) begin
         oe_cnt_q <= 8'h00;
      end else begin
         oe_cnt_q <= oe_cnt_q + 8'h01;
      end
   end
   a_pulse_len: assert property ($fell(rst_pin_oe) |-> oe_cnt_q == 8'h60)
      else $error("reset pulse length wrong");
   a_pulse_start: assert property (hw_watchdog_expire && !internal_reset |=> rst_pin_oe && rst_pin_out)
      else $error("reset pulse missing");
   a_pulse_resets: assert property (rst_pin_oe |=> internal_reset)
      else $error("no reset during pulse");
   a_supply_loss: assert property (!supply_safe [*5] |-> internal_reset)
      else $error("no reset on supply loss");
   a_array_reset: assert property (counter_array_wdt_expire |=> internal_reset)
      else $error("no reset on array watchdog");
   a_idle_entry: assert property (power_control_reg_wr.we && power_control_reg_wr.wdata[0] && !internal_reset && !enabled_irq
      |=> idle_active && !clk_ctl.cpu_clk_en)
      else $error("idle not entered");
   a_irq_exit: assert property (enabled_irq |=> !idle_active && !power_control_reg[0])
      else $error("idle not left on interrupt");
   a_idle_outs: assert property (idle_active |-> ale_force_high && program_store_strobe_force_high
      && clk_ctl.periph_clk_en && clk_ctl.hold_state && !clk_ctl.cpu_clk_en)
      else $error("idle outputs wrong");
   a_reset_exit: assert property (internal_reset |=> !idle_active)
      else $error("idle kept through reset");
   cover property ($fell(rst_pin_oe));
   cover property (idle_active ##1 !idle_active);
   cover property ($fell(internal_reset));
endmodule
`default_nettype wire

// *** verif/raic_board.sv ***
/* board model: crystal and wired reset pin.
   assumes the bench switches the oscillator and the outside reset. */
`timescale 1ns/1ps
`default_nettype none
module raic_board (
   input wire logic sys_clk,
   input wire logic osc_on,
   input wire logic ext_rst,
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic crystal_input,
   output logic rst_pin_in
);
   initial crystal_input = 1'b0;
   // crystal stands still while the oscillator is off
   always @(negedge sys_clk) if (osc_on) crystal_input <= ~crystal_input;
   assign rst_pin_in = ext_rst | (pin_oe & pin_out);
endmodule
`default_nettype wire

// *** verif/raic_reset_idle_tb.sv ***
/* bench for raic_reset_idle: power-up, then power control table, idle,
   pin, watchdog and supply cases. assumes raic_board beside the design. */
`timescale 1ns/1ps
`default_nettype none
module raic_reset_idle_tb;
   logic sys_clk, reset_n, supply_safe, crystal_input, rst_pin_in, rst_pin_out, rst_pin_oe;
   logic hw_watchdog_expire, counter_array_wdt_expire, enabled_irq, internal_reset;
   logic ale_force_high, program_store_strobe_force_high, idle_active, osc_on, ext_rst;
   logic [7:0] power_control_reg;
   raic_pkg::raic_power_control_reg_wr_t power_control_reg_wr;
   raic_pkg::raic_clk_ctl_t clk_ctl;
   int failures, compares, n;
   logic [15:0] rows [4] = '{16'heece, 16'h2000, 16'h1e1e, 16'hc0c0};
   raic_reset_idle raic_reset_idle_inst (.*);
   raic_board raic_board_inst (.sys_clk(sys_clk), .osc_on(osc_on), .ext_rst(ext_rst),
      .pin_out(rst_pin_out), .pin_oe(rst_pin_oe), .crystal_input(crystal_input),
      .rst_pin_in(rst_pin_in));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int lo, input int hi);
      compares++;
      if (got < lo || got > hi) begin
         failures++;
         $display("[ERR] %0t count %h exp %h..%h", $time, got, lo, hi);
      end
   endtask
   task automatic print_verdict();
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic ticks(input int k);
      repeat (k) @(negedge sys_clk);
   endtask
   task automatic wait_release(output int c);
      c = 0;
      while (internal_reset !== 1'b0 && c < 3000) begin
         ticks(1);
         c++;
      end
   endtask
   task automatic wr_power_control_reg(input logic [7:0] d);
      power_control_reg_wr = {1'b1, d};
      ticks(1);
      power_control_reg_wr = '0;
      ticks(1);
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      #100us;
      failures++;
      print_verdict();
   end
   initial begin
      {reset_n, supply_safe, osc_on, ext_rst, hw_watchdog_expire} = '0;
      {counter_array_wdt_expire, enabled_irq} = '0;
      power_control_reg_wr = '0;
      ticks(6);
      chk({7'h00, internal_reset}, 8'h01);
      chk(power_control_reg, 8'h10);
      reset_n = 1'b1;
      supply_safe = 1'b1;
      ticks(50);
      chk({7'h00, internal_reset}, 8'h01);
      osc_on = 1'b1;
      wait_release(n);
      chk_cnt(n, 1024, 1040);
      foreach (rows[i]) begin
         wr_power_control_reg(rows[i][15:8]);
         chk(power_control_reg, rows[i][7:0]);
      end
      wr_power_control_reg(8'h05);
      chk({2'h0, idle_active, clk_ctl, ale_force_high, program_store_strobe_force_high}, 8'h2f);
      ticks(4);
      enabled_irq = 1'b1;
      ticks(1);
      chk(power_control_reg, 8'h04);
      wr_power_control_reg(8'h01);
      enabled_irq = 1'b0;
      chk({7'h00, idle_active}, 8'h00);
      wr_power_control_reg(8'h01);
      ext_rst = 1'b1;
      ticks(26);
      chk({6'h00, idle_active, internal_reset}, 8'h01);
      ext_rst = 1'b0;
      wait_release(n);
      chk(power_control_reg, 8'h00);
      hw_watchdog_expire = 1'b1;
      ticks(1);
      hw_watchdog_expire = 1'b0;
      n = 0;
      while (rst_pin_oe === 1'b1 && n < 200) begin
         ticks(1);
         n++;
      end
      chk_cnt(n, 96, 96);
      wait_release(n);
      counter_array_wdt_expire = 1'b1;
      ticks(1);
      chk({7'h00, internal_reset}, 8'h01);
      counter_array_wdt_expire = 1'b0;
      ticks(1);
      wait_release(n);
      supply_safe = 1'b0;
      ticks(4);
      chk({7'h00, internal_reset}, 8'h01);
      print_verdict();
   end
endmodule
bind raic_reset_idle raic_props raic_props_inst (.*);
`default_nettype wire
